// ===== design/pssr_core.sv
// Processor state holder with exception save and restore
`timescale 1ns/1ps
`default_nettype none
module pssr_core
   import pssr_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              op_valid_in,
   input  wire pssr_op_e          op_code_in,
   input  wire pssr_view_e        op_view_in,
   input  wire logic [1:0]        op_level_in,
   input  wire logic [ADDR_W-1:0] op_wdata_in,
   input  wire logic [3:0]        op_imm_in,
   input  wire logic              exc_take_in,
   input  wire logic [1:0]        exc_target_in,
   input  wire logic [ADDR_W-1:0] exc_ret_addr_in,
   input  wire logic              step_en_in,
   input  wire pssr_a32_s         a32_in,
   input  wire logic [3:0]        exc_req_in,
   output logic [3:0]             exc_deliver_out,
   output pssr_state_s            state_out,
   output logic                   stack_own_out,
   output logic [ADDR_W-1:0]      rdata_out,
   output logic                   rvalid_out,
   output logic                   undef_out,
   output logic                   fetch_valid_out,
   output logic [ADDR_W-1:0]      fetch_addr_out
);
   pssr_state_s               st_reg;
   pssr_state_s               st_next;
   logic [SAVED_W-1:0]        saved_reg [3:1];
   logic [ADDR_W-1:0]         ret_reg [3:1];
   logic                      priv;
   logic                      bank_ok;
   logic                      legal;
   logic                      do_op;
   logic [SAVED_W-1:0]        cur_saved;
   logic [SAVED_W-1:0]        take_saved;
   logic [ADDR_W-1:0]         rd_val;

   assign priv = st_reg.el != 2'h0;
   assign bank_ok = op_level_in != 2'h0 && op_level_in <= st_reg.el;
   assign cur_saved = priv ? saved_reg[st_reg.el] : '0;

   // Access legality by level
   always_comb begin
      legal = 1'b0;
      case (op_code_in)
         OP_READ, OP_WRITE: begin
            case (op_view_in)
               VW_FLAGS: legal = 1'b1;
               VW_MASK, VW_STACK_SELECT_VIEW: legal = priv;
               VW_LEVEL: legal = priv && op_code_in == OP_READ;
               VW_SAVED, VW_RET: legal = priv && bank_ok;
               default: legal = 1'b0;
            endcase
         end
         OP_MSET, OP_MCLR, OP_SPIMM, OP_EXCEPTION_RETURN: legal = priv;
         default: legal = 1'b0;
      endcase
   end

   assign do_op = op_valid_in && !exc_take_in && legal;

   // Saved image of the state before entry
   always_comb begin
      take_saved = '0;
      take_saved[FLAGS_LSB +: 4] = {st_reg.n, st_reg.z, st_reg.c, st_reg.v};
      take_saved[ILL_POS] = st_reg.il;
      take_saved[WIDTH_POS] = st_reg.width;
      if (!st_reg.width) begin
         take_saved[STEP_POS] = step_en_in;
         take_saved[MASK_LSB +: 4] = st_reg.mask;
         take_saved[LEVEL_LSB +: 2] = st_reg.el;
         take_saved[STACK_SELECT_VIEW_POS] = st_reg.sp;
      end else begin
         take_saved[SAT_POS] = a32_in.q;
         take_saved[ITLO_LSB +: 2] = a32_in.it[1:0];
         take_saved[GE_LSB +: 4] = a32_in.ge;
         take_saved[ITHI_LSB +: 6] = a32_in.it[7:2];
         take_saved[END_POS] = a32_in.endian;
         take_saved[MASK_LSB +: 3] = st_reg.mask[2:0];
         take_saved[THUMB_POS] = a32_in.thumb;
         take_saved[3:0] = a32_in.mode;
      end
   end

   // Next processor state
   always_comb begin
      st_next = st_reg;
      if (exc_take_in) begin
         st_next.el = exc_target_in;
         st_next.width = 1'b0;
         st_next.mask[3] = 1'b1;
         st_next.sp = 1'b1;
         st_next.ss = 1'b0;
         st_next.il = 1'b0;
      end else if (do_op) begin
         case (op_code_in)
            OP_WRITE: begin
               case (op_view_in)
                  VW_FLAGS: {st_next.n, st_next.z, st_next.c, st_next.v} =
                     op_wdata_in[FLAGS_LSB +: 4];
                  VW_MASK: st_next.mask =
                     op_wdata_in[MASK_LSB +: 4];
                  VW_STACK_SELECT_VIEW: st_next.sp = op_wdata_in[STACK_SELECT_VIEW_POS];
                  default: st_next = st_reg;
               endcase
            end
            OP_MSET: st_next.mask = st_reg.mask | op_imm_in;
            OP_MCLR: st_next.mask = st_reg.mask & ~op_imm_in;
            OP_SPIMM: st_next.sp = op_imm_in[0];
            OP_EXCEPTION_RETURN: begin
               {st_next.n, st_next.z, st_next.c, st_next.v} =
                  cur_saved[FLAGS_LSB +: 4];
               st_next.ss = cur_saved[STEP_POS];
               st_next.il = cur_saved[ILL_POS];
               st_next.width = cur_saved[WIDTH_POS];
               if (!cur_saved[WIDTH_POS]) begin
                  st_next.mask = cur_saved[MASK_LSB +: 4];
                  st_next.el = cur_saved[LEVEL_LSB +: 2];
                  st_next.sp = cur_saved[STACK_SELECT_VIEW_POS];
               end else begin
                  st_next.mask = {st_reg.mask[3], cur_saved[MASK_LSB +: 3]};
                  st_next.el = (cur_saved[3:0] == MODE_A32_USER) ?
                               2'h0 : 2'h1;
                  st_next.sp = 1'b0;
               end
            end
            default: st_next = st_reg;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg <= '0;
         st_reg.el <= LEVEL_RST;
         st_reg.mask <= MASK_RST;
         st_reg.sp <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Banked saved state and return addresses
   for (genvar g = 1; g <= 3; g++) begin : g_bank
      always_ff @(posedge clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            saved_reg[g] <= '0;
            ret_reg[g] <= '0;
         end else if (exc_take_in) begin
            if (exc_target_in == 2'(g)) begin
               saved_reg[g] <= take_saved;
               ret_reg[g] <= exc_ret_addr_in;
            end
         end else if (do_op && op_code_in == OP_WRITE &&
                      op_level_in == 2'(g)) begin
            if (op_view_in == VW_SAVED)
               saved_reg[g] <= op_wdata_in[SAVED_W-1:0];
            if (op_view_in == VW_RET)
               ret_reg[g] <= op_wdata_in;
         end
      end
   end

   // Read data for move-from
   always_comb begin
      rd_val = '0;
      case (op_view_in)
         VW_FLAGS: rd_val[FLAGS_LSB +: 4] =
            {st_reg.n, st_reg.z, st_reg.c, st_reg.v};
         VW_MASK: rd_val[MASK_LSB +: 4] = st_reg.mask;
         VW_LEVEL: rd_val[LEVEL_LSB +: 2] = st_reg.el;
         VW_STACK_SELECT_VIEW: rd_val[STACK_SELECT_VIEW_POS] = st_reg.sp;
         VW_SAVED: rd_val[SAVED_W-1:0] = saved_reg[op_level_in];
         VW_RET: rd_val = ret_reg[op_level_in];
         default: rd_val = '0;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= '0;
         rvalid_out <= 1'b0;
      end else begin
         rvalid_out <= do_op && op_code_in == OP_READ;
         if (do_op && op_code_in == OP_READ)
            rdata_out <= rd_val;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         undef_out <= 1'b0;
      else
         undef_out <= op_valid_in && !exc_take_in && !legal;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fetch_valid_out <= 1'b0;
         fetch_addr_out <= '0;
      end else begin
         fetch_valid_out <= do_op && op_code_in == OP_EXCEPTION_RETURN;
         if (do_op && op_code_in == OP_EXCEPTION_RETURN)
            fetch_addr_out <= ret_reg[st_reg.el];
      end
   end

   assign state_out = st_reg;
   assign stack_own_out = st_reg.sp;
   assign exc_deliver_out = exc_req_in & ~st_reg.mask;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   mask_set_a: assert property (
      do_op && op_code_in == OP_MSET |=>
         st_reg.mask == ($past(st_reg.mask) | $past(op_imm_in)))
      else $error("mask set wrong");
   mask_clear_a: assert property (
      do_op && op_code_in == OP_MCLR |=>
         st_reg.mask == ($past(st_reg.mask) & ~$past(op_imm_in)))
      else $error("mask clear wrong");
   take_entry_a: assert property (
      exc_take_in |=> st_reg.mask[3] && st_reg.sp && !st_reg.width &&
         st_reg.el == $past(exc_target_in))
      else $error("exception entry state wrong");
   take_save_a: assert property (
      exc_take_in && !st_reg.width |=>
         saved_reg[st_reg.el][LEVEL_LSB +: 2] == $past(st_reg.el) &&
         saved_reg[st_reg.el][ILL_POS] == $past(st_reg.il))
      else $error("saved state wrong");
   exception_return_fetch_a: assert property (
      do_op && op_code_in == OP_EXCEPTION_RETURN |=>
         fetch_valid_out && fetch_addr_out == $past(ret_reg[st_reg.el]))
      else $error("return fetch address wrong");
   exception_return_level_a: assert property (
      do_op && op_code_in == OP_EXCEPTION_RETURN && !cur_saved[WIDTH_POS] |=>
         st_reg.el == $past(cur_saved[LEVEL_LSB +: 2]))
      else $error("return level wrong");
   level_zero_a: assert property (
      op_valid_in && !exc_take_in && st_reg.el == 2'h0 &&
      op_view_in != VW_FLAGS |=> undef_out && $stable(st_reg.mask))
      else $error("level zero access not undefined");
   read_pulse_a: assert property (
      rvalid_out |-> $past(op_code_in) == OP_READ && $stable(st_reg))
      else $error("read had a side effect");
   deliver_a: assert property (
      exc_deliver_out[0] |-> !st_reg.mask[0] && exc_req_in[0])
      else $error("masked fiq delivered");
endmodule
`default_nettype wire

// ===== include/pssr_pkg.sv
// Package: processor state fields, saved-state layout, op and view codes
// Function
// - Stack selector 0 picks level-zero stack, 1 the level's own; immediate sets it.
// - Level view reads back the current exception level.
// - Mask view reads and writes the four mask bits together.
// - Flags view reads and writes the four condition flags together.
// - Views read by move-from, written by move-to except the read-only level view, with no side effects.
// - Mask-set immediate sets each selected mask bit, others unchanged.
// - Mask-clear immediate clears each selected mask bit, others unchanged.
// - Exception return copies current level's saved state into the processor state.
// - After return, fetch continues at the returning level's return address.
// - Only the flags are reachable at level zero; anything else is undefined.
// - Taking an exception saves prior state into the target level's saved register.
// - 64-bit saved layout: flags 31:28, step 21, illegal 20, masks 9:6, width 4, mode 3:0.
// - 32-bit saved layout adds saturation, if-then, greater-equal, thumb fields.
// - Saved step bit records whether stepping was enabled at entry from 64-bit state; it is 0 on entry from 32-bit state.
// - Saved illegal bit records the illegal bit just before the exception.
// - Debug mask set to 1 at reset and on every exception taken.
// - Saved width bit records source width; low four bits record source mode.
// - A level's saved and return registers stay unchanged while running lower.
// - Taking an exception selects the target level's own stack pointer.
package pssr_pkg;
   localparam int ADDR_W = 64;
   localparam int SAVED_W = 32;
   // Saved-state bit positions
   localparam int FLAGS_LSB = 28;
   localparam int SAT_POS = 27;
   localparam int ITLO_LSB = 25;
   localparam int STEP_POS = 21;
   localparam int ILL_POS = 20;
   localparam int GE_LSB = 16;
   localparam int ITHI_LSB = 10;
   localparam int END_POS = 9;
   localparam int MASK_LSB = 6;
   localparam int THUMB_POS = 5;
   localparam int WIDTH_POS = 4;
   localparam int LEVEL_LSB = 2;
   localparam int STACK_SELECT_VIEW_POS = 0;
   // Reset values and 32-bit user mode code
   localparam logic [1:0] LEVEL_RST = 2'h3;
   localparam logic [3:0] MASK_RST = 4'hF;
   localparam logic [3:0] MODE_A32_USER = 4'h0;

   typedef struct packed {
      logic       n;
      logic       z;
      logic       c;
      logic       v;
      logic [3:0] mask;   // debug, serror, irq, fiq
      logic       ss;
      logic       il;
      logic [1:0] el;
      logic       width;  // 0 = 64-bit, 1 = 32-bit
      logic       sp;     // 0 = level-zero stack, 1 = own
   } pssr_state_s;

   typedef struct packed {
      logic       q;
      logic [7:0] it;
      logic [3:0] ge;
      logic       thumb;
      logic       endian;
      logic [3:0] mode;
   } pssr_a32_s;

   typedef enum logic [2:0] {
      OP_READ  = 3'b000,
      OP_WRITE = 3'b001,
      OP_MSET  = 3'b010,
      OP_MCLR  = 3'b011,
      OP_SPIMM = 3'b100,
      OP_EXCEPTION_RETURN  = 3'b101
   } pssr_op_e;

   typedef enum logic [2:0] {
      VW_FLAGS = 3'b000,
      VW_MASK  = 3'b001,
      VW_LEVEL = 3'b010,
      VW_STACK_SELECT_VIEW = 3'b011,
      VW_SAVED = 3'b100,
      VW_RET   = 3'b101
   } pssr_view_e;
endpackage

// ===== tb/pssr_core_tb_top.sv
// Self-checking testbench for the processor state holder
`timescale 1ns/1ps
`default_nettype none
module pssr_core_tb_top
   import pssr_pkg::*;
;
   logic              clk_in = 1'b0;
   logic              rst_n_in = 1'b0;
   logic              op_valid = 1'b0;
   pssr_op_e          op_code = OP_READ;
   pssr_view_e        op_view = VW_FLAGS;
   logic [1:0]        op_level = 2'h0;
   logic [63:0]       op_wdata = 64'h0;
   logic [3:0]        op_imm = 4'h0;
   logic              exc_take = 1'b0;
   logic [1:0]        exc_target = 2'h1;
   logic [63:0]       exc_ret = 64'h0;
   logic              step_en = 1'b0;
   logic [3:0]        exc_req = 4'h0;
   pssr_a32_s         a32 = '0;
   logic [3:0]        deliver;
   pssr_state_s       st;
   logic              stack_own;
   logic [63:0]       rdata;
   logic              rvalid;
   logic              undef;
   logic              fetch_valid;
   logic [63:0]       fetch_addr;
   int                mismatches = 0;
   int                n_compared = 0;

   always #2.5 clk_in = ~clk_in;

   pssr_core pssr_core_inst (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .op_valid_in(op_valid),
      .op_code_in(op_code), .op_view_in(op_view), .op_level_in(op_level),
      .op_wdata_in(op_wdata), .op_imm_in(op_imm), .exc_take_in(exc_take),
      .exc_target_in(exc_target), .exc_ret_addr_in(exc_ret),
      .step_en_in(step_en), .a32_in(a32), .exc_req_in(exc_req),
      .exc_deliver_out(deliver), .state_out(st), .stack_own_out(stack_own),
      .rdata_out(rdata), .rvalid_out(rvalid), .undef_out(undef),
      .fetch_valid_out(fetch_valid), .fetch_addr_out(fetch_addr));

   task automatic chk(input logic [63:0] g, input logic [63:0] e,
                      input string m);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   // One instruction, presented for one cycle; returns after its answer
   task automatic op(input pssr_op_e c, input pssr_view_e v,
                     input logic [1:0] l, input logic [63:0] w,
                     input logic [3:0] i);
      op_code = c;
      op_view = v;
      op_level = l;
      op_wdata = w;
      op_imm = i;
      op_valid = 1'b1;
      @(posedge clk_in);
      op_valid <= 1'b0;
      @(negedge clk_in);
   endtask

   task automatic take(input logic [1:0] t, input logic [63:0] r);
      exc_target = t;
      exc_ret = r;
      exc_take = 1'b1;
      @(posedge clk_in);
      exc_take <= 1'b0;
      @(negedge clk_in);
   endtask

   task automatic t_reset_and_flags();
      chk({st.el, st.mask, st.sp}, {2'h3, 4'hF, 1'b1}, "reset state");
      op(OP_WRITE, VW_FLAGS, 2'h0, 64'hA000_0000, 4'h0);
      chk({st.n, st.z, st.c, st.v}, 4'hA, "flags write");
      op(OP_READ, VW_FLAGS, 2'h0, 64'h0, 4'h0);
      chk({rvalid, rdata[31:28]}, {1'b1, 4'hA}, "flags read");
      chk(st.el, 2'h3, "read no side effect");
   endtask

   task automatic t_return_to_zero();
      op(OP_EXCEPTION_RETURN, VW_FLAGS, 2'h0, 64'h0, 4'h0);
      chk({fetch_valid, fetch_addr}, {1'b1, 64'h0}, "return fetch");
      chk({st.n, st.z, st.c, st.v, st.el, st.width}, 7'h0, "restore");
      op(OP_WRITE, VW_FLAGS, 2'h0, 64'h5000_0000, 4'h0);
      chk({st.n, st.z, st.c, st.v}, 4'h5, "level0 flags");
      op(OP_READ, VW_MASK, 2'h0, 64'h0, 4'h0);
      chk({undef, rvalid}, 2'b10, "level0 mask refused");
      op(OP_MSET, VW_MASK, 2'h0, 64'h0, 4'h1);
      chk(undef, 1'b1, "level0 mask set refused");
   endtask

   task automatic t_enter_level1();
      step_en = 1'b1;
      take(2'h1, 64'h1000);
      chk({st.el, st.mask[3], st.sp, st.width}, 5'h0E, "entry state");
      op(OP_READ, VW_SAVED, 2'h1, 64'h0, 4'h0);
      chk(rdata[31:0] & 32'hFFFF_FC3F, 32'h5020_0000, "saved l1");
      op(OP_READ, VW_LEVEL, 2'h0, 64'h0, 4'h0);
      chk(rdata[3:2], 2'h1, "level view");
      op(OP_MCLR, VW_MASK, 2'h0, 64'h0, 4'hF);
      op(OP_MSET, VW_MASK, 2'h0, 64'h0, 4'h6);
      chk(st.mask, 4'h6, "mask set");
      op(OP_MCLR, VW_MASK, 2'h0, 64'h0, 4'h2);
      chk(st.mask, 4'h4, "mask clear");
      op(OP_WRITE, VW_MASK, 2'h0, 64'h0000_0180, 4'h0);
      op(OP_READ, VW_MASK, 2'h0, 64'h0, 4'h0);
      chk(rdata[9:6], 4'h6, "mask view");
      op(OP_SPIMM, VW_STACK_SELECT_VIEW, 2'h0, 64'h0, 4'h0);
      chk({st.sp, stack_own}, 2'b00, "stack zero");
      op(OP_SPIMM, VW_STACK_SELECT_VIEW, 2'h0, 64'h0, 4'h1);
      op(OP_READ, VW_STACK_SELECT_VIEW, 2'h0, 64'h0, 4'h0);
      chk({stack_own, rdata[0]}, 2'b11, "stack own");
   endtask

   task automatic t_nest_and_return();
      take(2'h2, 64'h2000);
      chk(st.mask, 4'hE, "debug mask on entry");
      op(OP_READ, VW_SAVED, 2'h2, 64'h0, 4'h0);
      chk(rdata[31:0], 32'h5020_0185, "saved l2 layout");
      op(OP_READ, VW_SAVED, 2'h1, 64'h0, 4'h0);
      chk(rdata[31:0] & 32'hFFFF_FC3F, 32'h5020_0000, "l1 kept");
      op(OP_READ, VW_RET, 2'h1, 64'h0, 4'h0);
      chk(rdata, 64'h1000, "l1 return kept");
      op(OP_EXCEPTION_RETURN, VW_FLAGS, 2'h0, 64'h0, 4'h0);
      chk({fetch_valid, fetch_addr}, {1'b1, 64'h2000}, "fetch l2");
      chk({st.el, st.width, st.mask}, 7'h26, "restore l1");
      exc_req = 4'hF;
      #1;
      chk(deliver, 4'h9, "delivery masked");
      exc_req = 4'h0;
   endtask

   // Return into 32-bit user state, then take an exception from it
   task automatic t_narrow_round_trip();
      op(OP_WRITE, VW_SAVED, 2'h1, 64'h0000_0010, 4'h0);
      op(OP_EXCEPTION_RETURN, VW_FLAGS, 2'h0, 64'h0, 4'h0);
      chk({st.el, st.width, st.sp}, 4'h2, "return to narrow");
      a32.q = 1'b1;
      a32.it = 8'h81;
      a32.ge = 4'hA;
      a32.thumb = 1'b1;
      a32.endian = 1'b0;
      a32.mode = 4'h0;
      take(2'h1, 64'h3000);
      chk({st.el, st.width}, 3'h2, "entry from narrow");
      op(OP_READ, VW_SAVED, 2'h1, 64'h0, 4'h0);
      chk(rdata[31:0], 32'h0A0A_8030, "narrow saved layout");
   endtask

   task automatic summarize();
      if (mismatches == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(negedge clk_in);
      rst_n_in = 1'b1;
      @(negedge clk_in);
      t_reset_and_flags();
      t_return_to_zero();
      t_enter_level1();
      t_nest_and_return();
      t_narrow_round_trip();
      summarize();
   end

   initial begin
      #(5 * 2000);
      mismatches++;
      summarize();
   end
endmodule
`default_nettype wire
